//--- hw/slcr_top.v
// serial link control registers with sample-mark insertion path
//
// Overview of operation
// - mark enable puts timestamp in sample LSB
// - timestamp delayed same as its sample
// - eight-bit mode: mark LSB, seven data
// - twelve-bit mode: mark LSB, eleven data
// - ila control-bits count stays zero
// - link enable bit, resets to one
// - disabled link: reset, power down, gate
// - disabled link holds multiframe counter reset
// - frames register holds k minus one
// - 64b/66b mode takes k from 256*e/f
//
// Strobed register access was decided locally.

`include "slcr_map.vh"

module slcr_top (
   // clock and reset
   input  wire                    i_clk_sys,
   input  wire                    i_sys_rst,
   // register port
   input  wire [`SLCR_AW-1:0]     i_reg_addr,
   input  wire [`SLCR_DW-1:0]     i_reg_wdata,
   input  wire                    i_reg_wr,
   input  wire                    i_reg_rd,
   output reg  [`SLCR_DW-1:0]     o_reg_rdata,
   // timestamp and sysref pins
   input  wire                    i_stamp_pin,
   input  wire                    i_sysref_pin,
   // sample stream in
   input  wire [`SLCR_SW-1:0]     i_smp_data,
   input  wire                    i_smp_valid,
   output reg                     o_smp_ready,
   // sample stream out
   output reg  [`SLCR_SW-1:0]     o_smp_data,
   output reg                     o_smp_valid,
   input  wire                    i_smp_ready,
   // link control outputs
   output reg                     o_link_rst,
   output reg                     o_serdes_pd,
   output reg                     o_link_clk_en,
   output reg                     o_sync_receiver_enable,
   output reg                     o_cal_en,
   output reg  [`SLCR_DW-1:0]     o_link_mode,
   output reg  [1:0]              o_ila_cs,
   output reg  [`SLCR_KW-1:0]     o_k_minus_one,
   output reg                     o_mf_boundary
);

   // software registers
   reg  [`SLCR_DW-1:0]  mark_ctrl_r;   // sample mark control
   reg  [`SLCR_DW-1:0]  link_en_r;     // link enable
   reg  [`SLCR_DW-1:0]  link_mode_r;   // link mode setting
   reg  [`SLCR_DW-1:0]  km1_r;         // frames per multiframe minus one
   reg  [`SLCR_DW-1:0]  link_cfg_r;    // format, layer, sync rx, cal
   reg  [`SLCR_DW-1:0]  link_ef_r;     // e and f for 64b/66b

   // pin synchronisers
   reg                  stamp_s1_r;    // first stage, stamp
   reg                  stamp_s2_r;    // second stage, stamp
   reg                  sysref_s1_r;   // first stage, sysref
   reg                  sysref_s2_r;   // second stage, sysref
   reg                  sysref_d_r;    // sysref edge history

   // sample delay line matching synchroniser depth
   reg  [`SLCR_SW-1:0]  d1_data_r;     // stage one data
   reg                  d1_vld_r;      // stage one valid
   reg  [`SLCR_SW-1:0]  d2_data_r;     // stage two data
   reg                  d2_vld_r;      // stage two valid

   // two-entry output buffer
   reg  [`SLCR_SW-1:0]  buf0_r;        // head entry
   reg  [`SLCR_SW-1:0]  buf1_r;        // second entry
   reg  [1:0]           cnt_r;         // entries held
   reg  [1:0]           cnt_nxt;       // next entries held

   // multiframe counter
   reg  [`SLCR_KW-1:0]  mf_cnt_r;      // frame position

   // decoded controls
   wire                 link_on;       // link enabled
   wire                 mark_on;       // mark insertion on
   wire                 eight_bit;     // eight-bit sample mode
   wire                 ll_64b66b;     // 64b/66b link layer
   wire [`SLCR_KW-1:0]  k_m1_eff;      // effective k minus one
   wire                 push;          // delayed sample into buffer
   wire                 pop;           // buffer head taken downstream
   wire                 accept;        // input sample taken
   wire [`SLCR_SW-1:0]  marked;        // sample with mark inserted
   wire                 sysref_rise;   // sysref rising edge
   wire [2:0]           occ_nxt;       // buffer plus in-flight next

   // register address match
   function hit;
      input [`SLCR_AW-1:0] addr;
      input [`SLCR_AW-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // insert the mark bit at the sample LSB
   function [`SLCR_SW-1:0] mark_sample;
      input [`SLCR_SW-1:0] smp;
      input                stamp;
      input                en;
      input                eight;
      begin
         if (!en) begin
            mark_sample = smp;
         end else if (eight) begin
            // upper seven bits of data, mark at bit 0
            mark_sample = {4'h0, smp[11:5], stamp};
         end else begin
            // upper eleven bits of data, mark at bit 0
            mark_sample = {smp[11:1], stamp};
         end
      end
   endfunction

   // k minus one from e and f for 64b/66b
   function [`SLCR_KW-1:0] k_from_ef;
      input [3:0] e;
      input [3:0] f;
      reg   [`SLCR_KW-1:0] prod;
      reg   [`SLCR_KW-1:0] fw;
      begin
         prod = `SLCR_KBASE_64B66B * {8'h00, e};
         fw   = {8'h00, f};
         if (fw == {`SLCR_KW{1'b0}}) begin
            k_from_ef = prod - `SLCR_ONE_K;
         end else begin
            k_from_ef = (prod / fw) - `SLCR_ONE_K;
         end
      end
   endfunction

   assign link_on   = link_en_r[`SLCR_BIT_LINK_EN];
   assign mark_on   = mark_ctrl_r[`SLCR_BIT_MARK_EN];
   assign eight_bit = link_cfg_r[`SLCR_BIT_EIGHT_BIT];
   assign ll_64b66b = link_cfg_r[`SLCR_BIT_LL_64B66B];

   // pick the frame count source
   assign k_m1_eff = ll_64b66b ?
      k_from_ef(link_ef_r[`SLCR_EF_E_LSB +: 4],
                link_ef_r[`SLCR_EF_F_LSB +: 4]) :
      {4'h0, km1_r};

   assign accept      = i_smp_valid & o_smp_ready & link_on;
   assign push        = d2_vld_r;
   assign pop         = o_smp_valid & i_smp_ready;
   assign marked      = mark_sample(d2_data_r, stamp_s2_r,
                                    mark_on, eight_bit);
   assign sysref_rise = sysref_s2_r & ~sysref_d_r;

   // register writes
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mark_ctrl_r <= `SLCR_RST_MARK_CTRL;
         link_en_r   <= `SLCR_RST_LINK_EN;
         link_mode_r <= `SLCR_RST_LINK_MODE;
         km1_r       <= `SLCR_RST_KM1;
         link_cfg_r  <= `SLCR_RST_LINK_CFG;
         link_ef_r   <= `SLCR_RST_LINK_EF;
      end else if (i_reg_wr) begin
         // single decoded write
         if (hit(i_reg_addr, `SLCR_OFS_MARK_CTRL)) begin
            mark_ctrl_r <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SLCR_OFS_LINK_EN)) begin
            link_en_r <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SLCR_OFS_LINK_MODE)) begin
            link_mode_r <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SLCR_OFS_KM1)) begin
            km1_r <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SLCR_OFS_LINK_CFG)) begin
            link_cfg_r <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SLCR_OFS_LINK_EF)) begin
            link_ef_r <= i_reg_wdata;
         end
      end
   end

   // register reads, data one cycle later
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= {`SLCR_DW{1'b0}};
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `SLCR_OFS_MARK_CTRL: o_reg_rdata <= mark_ctrl_r;
            `SLCR_OFS_LINK_EN:   o_reg_rdata <= link_en_r;
            `SLCR_OFS_LINK_MODE: o_reg_rdata <= link_mode_r;
            `SLCR_OFS_KM1:       o_reg_rdata <= km1_r;
            `SLCR_OFS_LINK_CFG:  o_reg_rdata <= link_cfg_r;
            `SLCR_OFS_LINK_EF:   o_reg_rdata <= link_ef_r;
            // live state: buffer fill and link on
            `SLCR_OFS_STATUS:    o_reg_rdata <= {5'h00, cnt_r, link_on};
            default:             o_reg_rdata <= {`SLCR_DW{1'b0}};
         endcase
      end else begin
         // data stand one cycle only
         o_reg_rdata <= {`SLCR_DW{1'b0}};
      end
   end

   // pin synchronisers, two flops each
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stamp_s1_r  <= 1'b0;
         stamp_s2_r  <= 1'b0;
         sysref_s1_r <= 1'b0;
         sysref_s2_r <= 1'b0;
         sysref_d_r  <= 1'b0;
      end else begin
         stamp_s1_r  <= i_stamp_pin;
         stamp_s2_r  <= stamp_s1_r;
         sysref_s1_r <= i_sysref_pin;
         sysref_s2_r <= sysref_s1_r;
         sysref_d_r  <= sysref_s2_r;
      end
   end

   // two-stage sample delay equal to the stamp synchroniser
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         d1_data_r <= {`SLCR_SW{1'b0}};
         d1_vld_r  <= 1'b0;
         d2_data_r <= {`SLCR_SW{1'b0}};
         d2_vld_r  <= 1'b0;
      end else if (!link_on) begin
         // link held in reset
         d1_vld_r <= 1'b0;
         d2_vld_r <= 1'b0;
      end else begin
         // stamp and sample share equal delay
         d1_data_r <= i_smp_data;
         d1_vld_r  <= accept;
         d2_data_r <= d1_data_r;
         d2_vld_r  <= d1_vld_r;
      end
   end

   // buffer fill count
   always @* begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   // room left, counting samples still in the delay line
   assign occ_nxt = {1'b0, cnt_nxt} + {2'h0, d1_vld_r & link_on}
                  + {2'h0, accept};

   // two-entry buffer with stall toward the source
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         buf0_r      <= {`SLCR_SW{1'b0}};
         buf1_r      <= {`SLCR_SW{1'b0}};
         cnt_r       <= 2'h0;
         o_smp_ready <= 1'b0;
      end else if (!link_on) begin
         // link held in reset, buffer flushed
         cnt_r       <= 2'h0;
         o_smp_ready <= 1'b0;
      end else begin
         cnt_r       <= cnt_nxt;
         o_smp_ready <= (occ_nxt < {1'b0, `SLCR_BUF_DEPTH});
         if (pop) begin
            // shift head forward
            buf0_r <= buf1_r;
            if (push && cnt_r == 2'h1) begin
               buf0_r <= marked;
            end else if (push) begin
               buf1_r <= marked;
            end
         end else if (push) begin
            // fill first free entry
            if (cnt_r == 2'h0) begin
               buf0_r <= marked;
            end else begin
               buf1_r <= marked;
            end
         end
      end
   end

   // output stage follows the buffer head
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_smp_data  <= {`SLCR_SW{1'b0}};
         o_smp_valid <= 1'b0;
      end else begin
         o_smp_valid <= link_on && (cnt_nxt != 2'h0);
         if (pop || !o_smp_valid) begin
            // next head after this cycle
            if (pop && cnt_r == 2'h2) begin
               o_smp_data <= buf1_r;
            end else if (pop && cnt_r == 2'h1) begin
               o_smp_data <= marked;
            end else if (cnt_r == 2'h0) begin
               o_smp_data <= marked;
            end else begin
               o_smp_data <= buf0_r;
            end
         end
      end
   end

   // multiframe counter, realigned by sysref
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mf_cnt_r      <= {`SLCR_KW{1'b0}};
         o_mf_boundary <= 1'b0;
      end else if (!link_on) begin
         // held so sysref cannot realign
         mf_cnt_r      <= {`SLCR_KW{1'b0}};
         o_mf_boundary <= 1'b0;
      end else if (sysref_rise) begin
         mf_cnt_r      <= {`SLCR_KW{1'b0}};
         o_mf_boundary <= 1'b1;
      end else if (mf_cnt_r >= k_m1_eff) begin
         // wrap after k frames
         mf_cnt_r      <= {`SLCR_KW{1'b0}};
         o_mf_boundary <= 1'b1;
      end else begin
         mf_cnt_r      <= mf_cnt_r + `SLCR_ONE_K;
         o_mf_boundary <= 1'b0;
      end
   end

   // link power and control outputs
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_link_rst     <= 1'b1;
         o_serdes_pd    <= 1'b1;
         o_link_clk_en  <= 1'b0;
         o_sync_receiver_enable <= 1'b0;
         o_cal_en       <= 1'b0;
         o_link_mode    <= `SLCR_RST_LINK_MODE;
         o_ila_cs       <= `SLCR_CS_ILA;
         o_k_minus_one  <= {4'h0, `SLCR_RST_KM1};
      end else begin
         o_link_rst     <= ~link_on;
         o_serdes_pd    <= ~link_on;
         o_link_clk_en  <= link_on;
         o_sync_receiver_enable <= link_cfg_r[`SLCR_BIT_SYNC_RX_EN];
         o_cal_en       <= link_cfg_r[`SLCR_BIT_CAL_EN];
         o_link_mode    <= link_mode_r;
         o_ila_cs       <= `SLCR_CS_ILA;
         o_k_minus_one  <= k_m1_eff;
      end
   end

endmodule // slcr_top

//--- hw/slcr_map.vh
// register map and field constants for the serial link control registers
`ifndef SLCR_MAP_VH
`define SLCR_MAP_VH

// register offsets
`define SLCR_OFS_MARK_CTRL   10'h160
`define SLCR_OFS_LINK_EN     10'h200
`define SLCR_OFS_LINK_MODE   10'h201
`define SLCR_OFS_KM1         10'h202
`define SLCR_OFS_LINK_CFG    10'h210
`define SLCR_OFS_LINK_EF     10'h211
`define SLCR_OFS_STATUS      10'h212

// reset values
`define SLCR_RST_MARK_CTRL   8'h00
`define SLCR_RST_LINK_EN     8'h01
`define SLCR_RST_LINK_MODE   8'h02
`define SLCR_RST_KM1         8'h1f
`define SLCR_RST_LINK_CFG    8'h00
`define SLCR_RST_LINK_EF     8'h11

// field positions
`define SLCR_BIT_MARK_EN     0
`define SLCR_BIT_LINK_EN     0
`define SLCR_BIT_EIGHT_BIT   0
`define SLCR_BIT_LL_64B66B   1
`define SLCR_BIT_SYNC_RX_EN  2
`define SLCR_BIT_CAL_EN      3
`define SLCR_EF_F_LSB        0
`define SLCR_EF_E_LSB        4

// widths and counts
`define SLCR_AW              10
`define SLCR_DW              8
`define SLCR_SW              12
`define SLCR_KW              12
`define SLCR_KBASE_64B66B    12'h100
`define SLCR_BUF_DEPTH       2'h2
`define SLCR_ONE_K           12'h001
`define SLCR_CS_ILA          2'h0

`endif

//--- sim/slcr_sva.sv
// assertion checker bound to the serial link control register top
`include "slcr_map.vh"
module slcr_sva (
   // clock and reset
   input wire                    i_clk_sys,
   input wire                    i_sys_rst,
   // register port
   input wire [`SLCR_AW-1:0]     i_reg_addr,
   input wire [`SLCR_DW-1:0]     i_reg_wdata,
   input wire                    i_reg_wr,
   input wire                    i_reg_rd,
   input wire [`SLCR_DW-1:0]     o_reg_rdata,
   // sample stream
   input wire                    o_smp_ready,
   input wire [`SLCR_SW-1:0]     o_smp_data,
   input wire                    o_smp_valid,
   input wire                    i_smp_ready,
   // link control
   input wire                    o_link_rst,
   input wire                    o_serdes_pd,
   input wire                    o_link_clk_en,
   input wire [1:0]              o_ila_cs,
   input wire                    o_mf_boundary
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // address decode of the stored registers
   wire stored = (i_reg_addr == `SLCR_OFS_MARK_CTRL) ||
      (i_reg_addr == `SLCR_OFS_LINK_EN) || (i_reg_addr == `SLCR_OFS_LINK_MODE)
      || (i_reg_addr == `SLCR_OFS_KM1) || (i_reg_addr == `SLCR_OFS_LINK_CFG)
      || (i_reg_addr == `SLCR_OFS_LINK_EF);
   wire unmapped = !stored && (i_reg_addr != `SLCR_OFS_STATUS);
   property p_ila_zero; o_ila_cs == 2'h0; endproperty
   a_ila_zero: assert property (p_ila_zero)
      else $error("ila control bits not zero");
   property p_off_gated; o_link_rst |-> o_serdes_pd && !o_link_clk_en;
   endproperty
   a_off_gated: assert property (p_off_gated)
      else $error("disabled link not powered down");
   property p_off_no_input; o_link_rst |-> !o_smp_ready; endproperty
   a_off_no_input: assert property (p_off_no_input)
      else $error("disabled link accepts samples");
   property p_off_no_out; o_link_rst [*3] |-> !o_smp_valid; endproperty
   a_off_no_out: assert property (p_off_no_out)
      else $error("disabled link still sends samples");
   property p_off_no_mf; o_link_rst [*2] |-> !o_mf_boundary; endproperty
   a_off_no_mf: assert property (p_off_no_mf)
      else $error("multiframe pulse while link disabled");
   property p_hold;
      o_smp_valid && !i_smp_ready && !o_link_rst |=>
         (o_smp_valid && $stable(o_smp_data)) or (1'b1 ##1 o_link_rst);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stalled sample dropped or changed");
   property p_rd_idle; !i_reg_rd |=> o_reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read");
   property p_unmapped; i_reg_rd && unmapped |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_wr_rd;
      i_reg_wr && stored ##1 i_reg_rd && $stable(i_reg_addr) |=>
         o_reg_rdata == $past(i_reg_wdata, 2);
   endproperty
   a_wr_rd: assert property (p_wr_rd)
      else $error("register read back differs");
   property p_link_follow;
      i_reg_wr && i_reg_addr == `SLCR_OFS_LINK_EN |->
         ##2 o_link_rst == !$past(i_reg_wdata[`SLCR_BIT_LINK_EN], 2);
   endproperty
   a_link_follow: assert property (p_link_follow)
      else $error("link reset does not follow enable");
   c_mark: cover property (o_smp_valid && i_smp_ready && o_smp_data[0]);
   c_stall: cover property (o_smp_valid && !i_smp_ready);
   c_mf: cover property (o_mf_boundary);
endmodule // slcr_sva

bind slcr_top slcr_sva u_sva (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_smp_ready(o_smp_ready),
   .o_smp_data(o_smp_data), .o_smp_valid(o_smp_valid),
   .i_smp_ready(i_smp_ready), .o_link_rst(o_link_rst),
   .o_serdes_pd(o_serdes_pd), .o_link_clk_en(o_link_clk_en),
   .o_ila_cs(o_ila_cs), .o_mf_boundary(o_mf_boundary));

//--- sim/slcr_sink.sv
// far-side receiver model: takes samples, ready prompt, slow or stopped
module slcr_sink (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // sample stream from the block
   input  wire logic        i_valid,
   input  wire logic [11:0] i_data,
   output logic             o_ready,
   // pacing: 0 prompt, 1 ready one cycle in four, 2 stopped
   input  wire logic [1:0]  i_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  pace_r;  // pacing counter
   logic [11:0] rx_q[$]; // words taken, in arrival order
   // handshake and capture
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pace_r  <= 2'h0;
         o_ready <= 1'b0;
      end else begin
         pace_r  <= pace_r + 2'h1;
         o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && pace_r == 2'h3);
         if (i_valid && o_ready) rx_q.push_back(i_data);
      end
   end
endmodule // slcr_sink

//--- sim/testbench.sv
// self-checking bench for the serial link control registers
`include "slcr_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [9:0] a;
      logic [7:0] w, r, b;
   } slcr_row_t;
   // design inputs
   logic        i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd;
   logic [9:0]  i_reg_addr;
   logic [7:0]  i_reg_wdata;
   logic        i_stamp_pin, i_sysref_pin, i_smp_valid;
   logic [11:0] i_smp_data;
   logic [1:0]  sink_mode;
   // design outputs
   wire  [7:0]  o_reg_rdata, o_link_mode;
   wire  [11:0] o_smp_data, o_k_minus_one;
   wire  [1:0]  o_ila_cs;
   wire         o_smp_ready, o_smp_valid, sink_rdy, o_link_rst, o_serdes_pd;
   wire         o_link_clk_en, o_sync_receiver_enable, o_cal_en, o_mf_boundary;
   int          errors, n_checks, n, base, acc;
   logic [11:0] d, exp_q[6];
   logic        s;
   // address, write, reset value, read back
   slcr_row_t   rows[8] = '{'{10'h200, 8'h00, 8'h01, 8'h00},
      '{10'h160, 8'ha4, 8'h00, 8'ha4}, '{10'h201, 8'h5a, 8'h02, 8'h5a},
      '{10'h202, 8'h0b, 8'h1f, 8'h0b}, '{10'h210, 8'h0c, 8'h00, 8'h0c},
      '{10'h211, 8'h42, 8'h11, 8'h42}, '{10'h203, 8'h77, 8'h00, 8'h00},
      '{10'h3ff, 8'h77, 8'h00, 8'h00}};
   logic [7:0]  mc[3] = '{8'h0c, 8'h0c, 8'h0d}; // stream configs
   logic        mm[3] = '{1'b1, 1'b0, 1'b1};    // mark enable per config
   slcr_top DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .i_stamp_pin(i_stamp_pin), .i_sysref_pin(i_sysref_pin),
      .i_smp_data(i_smp_data), .i_smp_valid(i_smp_valid),
      .o_smp_ready(o_smp_ready), .o_smp_data(o_smp_data),
      .o_smp_valid(o_smp_valid), .i_smp_ready(sink_rdy),
      .o_link_rst(o_link_rst), .o_serdes_pd(o_serdes_pd),
      .o_link_clk_en(o_link_clk_en), .o_sync_receiver_enable(o_sync_receiver_enable),
      .o_cal_en(o_cal_en), .o_link_mode(o_link_mode), .o_ila_cs(o_ila_cs),
      .o_k_minus_one(o_k_minus_one), .o_mf_boundary(o_mf_boundary));
   slcr_sink u_sink (.i_clk(i_clk_sys), .i_rst(i_sys_rst),
      .i_valid(o_smp_valid), .i_data(o_smp_data), .o_ready(sink_rdy),
      .i_mode(sink_mode));
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic test_done;
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one write cycle then an idle cycle
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      i_reg_addr  <= a;
      i_reg_wdata <= v;
      i_reg_wr    <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   // read with data checked in the cycle after the strobe
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      @(posedge i_clk_sys);
      chk(o_reg_rdata, exp);
   endtask
   // write followed at once by a read of the same place
   task automatic wrrd(input logic [9:0] a, input logic [7:0] v,
                       input logic [7:0] exp);
      i_reg_addr  <= a;
      i_reg_wdata <= v;
      i_reg_wr    <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      @(posedge i_clk_sys);
      chk(o_reg_rdata, exp);
   endtask
   // offer one sample with its stamp until taken
   task automatic send(input logic [11:0] v, input logic st);
      i_smp_data  <= v;
      i_stamp_pin <= st;
      i_smp_valid <= 1'b1;
      n = 0;
      @(posedge i_clk_sys);
      while (o_smp_ready !== 1'b1 && n < 50) begin
         @(posedge i_clk_sys);
         n++;
      end
   endtask
   // cycles until the next multiframe pulse
   task automatic mf_gap;
      n = 0;
      @(posedge i_clk_sys);
      while (o_mf_boundary !== 1'b1 && n < 600) begin
         @(posedge i_clk_sys);
         n++;
      end
   endtask
   // expected word leaving the block
   function automatic logic [11:0] exp_smp(input logic [7:0] c,
      input logic m, input logic [11:0] v, input logic st);
      if (!m) return v;
      if (c[`SLCR_BIT_EIGHT_BIT]) return {4'h0, v[11:5], st};
      return {v[11:1], st};
   endfunction
   // 40 MHz clock
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      errors++;
      test_done;
   end
   // main sequence
   initial begin
      {i_reg_wr, i_reg_rd, i_stamp_pin, i_sysref_pin, i_smp_valid} = 5'h00;
      {i_reg_addr, i_reg_wdata, i_smp_data} = 30'h0;
      sink_mode = 2'h0;
      i_sys_rst = 1'b1;
      repeat (8) @(posedge i_clk_sys);
      chk(o_link_rst, 1'b1);
      chk(o_k_minus_one, 12'h01f);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      chk(o_link_rst, 1'b0);
      foreach (rows[i]) begin
         rd(rows[i].a, rows[i].r);
         wrrd(rows[i].a, rows[i].w, rows[i].b);
      end
      chk(o_k_minus_one, 12'h00b);
      chk(o_link_mode, 8'h5a);
      chk({o_sync_receiver_enable, o_cal_en}, 2'h3);
      i_sysref_pin <= 1'b1;
      acc = 0;
      repeat (12) begin
         @(posedge i_clk_sys);
         i_sysref_pin <= 1'b0;
         if (o_mf_boundary === 1'b1) acc++;
      end
      chk(acc, 0);
      wr(`SLCR_OFS_LINK_EN, 8'h01);
      mf_gap;
      mf_gap;
      chk(n, 11);
      // sysref edge while enabled restarts the multiframe count
      i_sysref_pin <= 1'b1;
      @(posedge i_clk_sys);
      i_sysref_pin <= 1'b0;
      mf_gap;
      chk(n, 2);
      foreach (mc[i]) begin
         wr(`SLCR_OFS_LINK_EN, 8'h00);
         wr(`SLCR_OFS_LINK_CFG, mc[i]);
         wr(`SLCR_OFS_MARK_CTRL, {7'h00, mm[i]});
         wr(`SLCR_OFS_LINK_EN, 8'h01);
         sink_mode <= 2'h1;
         base = u_sink.rx_q.size();
         for (int j = 0; j < 6; j++) begin
            d = 12'h9c5 + j * 12'h3a1;
            s = j[0] ^ j[1];
            exp_q[j] = exp_smp(mc[i], mm[i], d, s);
            send(d, s);
         end
         i_smp_valid <= 1'b0;
         n = 0;
         while (u_sink.rx_q.size() < base + 6 && n < 200) begin
            @(posedge i_clk_sys);
            n++;
         end
         for (int j = 0; j < 6; j++)
            chk(u_sink.rx_q[base + j], exp_q[j]);
         chk(o_ila_cs, 2'h0);
      end
      sink_mode <= 2'h2;
      repeat (2) @(posedge i_clk_sys);
      i_smp_valid <= 1'b1;
      acc = 0;
      repeat (12) begin
         @(posedge i_clk_sys);
         if (o_smp_ready === 1'b1) acc++;
      end
      i_smp_valid <= 1'b0;
      chk(acc, 2);
      // status: two entries held, link on
      rd(`SLCR_OFS_STATUS, 8'h05);
      base = u_sink.rx_q.size();
      sink_mode <= 2'h0;
      repeat (12) @(posedge i_clk_sys);
      chk(u_sink.rx_q.size() - base, 2);
      chk(o_smp_valid, 1'b0);
      wr(`SLCR_OFS_LINK_EN, 8'h00);
      wr(`SLCR_OFS_LINK_EF, 8'h42);
      wr(`SLCR_OFS_LINK_CFG, 8'h0e);
      @(posedge i_clk_sys);
      chk(o_k_minus_one, 12'h1ff);
      chk({o_link_rst, o_serdes_pd, o_link_clk_en}, 3'h6);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      rd(`SLCR_OFS_KM1, 8'h1f);
      rd(`SLCR_OFS_LINK_EN, 8'h01);
      test_done;
   end
endmodule // testbench
